/* ccd_timing_gen.sv */
// Timing generator end: integration, line shifts and pixel readout with binning.
// Assumes the sensor end updates video on the edge after it sees H3 fall.
// What this block does
// [R1] Read 512 lines of 528 samples each (16 dark, 512 image)
// [R2] Three vertical phases move rows after integration
// [R3] Gate high moves bottom row into serial register
// [R4] Transfer gate follows the second vertical phase
// [R5] Three horizontal phases shift one cell per cycle
// [R6] Sixteen empty cells lead each line
// [R7] Sample video after third horizontal phase falls
// [R8] Reset clock precharges; skip it to bin pixels
// [R9] Serial cells sum two rows for vertical binning
// [R10] Pinned mode holds all vertical phases low
// [R11] Buried mode holds one vertical phase high
// [R12] 1 MHz pixels, six microsecond line shift
// [R13] Shift lines first, then 528 horizontal cycles
`timescale 1ns/1ps
module ccd_timing_gen #(
  parameter int ROWS = ccd_seq_pkg::ROWS,
  parameter int COLS = ccd_seq_pkg::COLS,
  parameter int DARK_CELLS = ccd_seq_pkg::DARK_CELLS,
  parameter int H_CLKS = ccd_seq_pkg::H_CYCLE_CLKS,
  parameter int V_CLKS = ccd_seq_pkg::V_SHIFT_CLKS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  ccd_link_if.timing_gen link,
  input wire logic i_start,
  input wire logic i_pinned_mode,
  input wire logic [31:0] i_integ_clks,
  input wire logic i_vbin_two,
  input wire logic i_hbin_two,
  output logic o_busy,
  output logic o_frame_done,
  output logic [ccd_seq_pkg::NODE_W-1:0] o_sample,
  output logic o_sample_valid,
  output logic o_sample_dark,
  output logic [ccd_seq_pkg::ROW_W-1:0] o_sample_line
);
  localparam int IW = ccd_seq_pkg::CELL_IDX_W;
  localparam int RW = ccd_seq_pkg::ROW_W;
  localparam logic [IW-1:0] LAST_CELL = IW'(DARK_CELLS + COLS - 1);
  localparam logic [IW-1:0] DARK_END = IW'(DARK_CELLS);

  typedef enum logic [1:0] {ST_IDLE, ST_INTEG, ST_VSHIFT, ST_HREAD} tgen_state_e;

  tgen_state_e state_q, state_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] integ_q, integ_d;
  logic pinned_q, pinned_d;
  logic vbin_q, vbin_d;
  logic hbin_q, hbin_d;
  logic vrow_q, vrow_d;
  logic [RW-1:0] line_q, line_d;
  logic [IW-1:0] pix_q, pix_d;
  logic done_q, done_d;
  logic [RW-1:0] last_line;
  logic [2:0] vseq_phase;
  logic [2:0] hseq_phase;
  logic v_end;
  logic h_end;

  ////////////////////////////////////////////////////////////////////////////
  // Phase generators at the line shift and pixel rates
  phase_sequencer #(.CYCLE_CLKS(V_CLKS)) u_vseq ( // [R12]
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_run(state_q == ST_VSHIFT),
    .o_phase(vseq_phase),
    .o_cycle_end(v_end)
  );

  phase_sequencer #(.CYCLE_CLKS(H_CLKS)) u_hseq ( // [R12]
    .i_ref_clk(i_ref_clk),
    .i_rst_n(i_rst_n),
    .i_run(state_q == ST_HREAD),
    .o_phase(hseq_phase),
    .o_cycle_end(h_end)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencing
  assign last_line = vbin_q ? RW'(ROWS / 2 - 1) : RW'(ROWS - 1); // [R1] [R9]

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    integ_d = integ_q;
    pinned_d = pinned_q;
    vbin_d = vbin_q;
    hbin_d = hbin_q;
    vrow_d = vrow_q;
    line_d = line_q;
    pix_d = pix_q;
    done_d = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (i_start) begin
          integ_d = i_integ_clks;
          pinned_d = i_pinned_mode;
          vbin_d = i_vbin_two;
          hbin_d = i_hbin_two;
          cnt_d = '0;
          vrow_d = 1'b0;
          line_d = '0;
          state_d = ST_INTEG;
        end
      end
      ST_INTEG: begin
        if (cnt_q >= integ_q) begin
          state_d = ST_VSHIFT; // [R2]
        end else begin
          cnt_d = cnt_q + 32'h1;
        end
      end
      ST_VSHIFT: begin
        if (v_end) begin
          // Second shift sums a further row into the same serial cells
          if (vrow_q == vbin_q) begin // [R9] [R13]
            vrow_d = 1'b0;
            pix_d = '0;
            state_d = ST_HREAD;
          end else begin
            vrow_d = 1'b1;
          end
        end
      end
      ST_HREAD: begin
        if (h_end) begin
          if (pix_q == LAST_CELL) begin // [R13] [R6]
            pix_d = '0;
            if (line_q == last_line) begin
              line_d = '0;
              done_d = 1'b1;
              state_d = ST_IDLE;
            end else begin
              line_d = line_q + 1'b1;
              state_d = ST_VSHIFT;
            end
          end else begin
            pix_d = pix_q + 1'b1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= ST_IDLE;
      cnt_q <= '0;
      integ_q <= '0;
      pinned_q <= 1'b0;
      vbin_q <= 1'b0;
      hbin_q <= 1'b0;
      vrow_q <= 1'b0;
      line_q <= '0;
      pix_q <= '0;
      done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      integ_q <= integ_d;
      pinned_q <= pinned_d;
      vbin_q <= vbin_d;
      hbin_q <= hbin_d;
      vrow_q <= vrow_d;
      line_q <= line_d;
      pix_q <= pix_d;
      done_q <= done_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link drive
  always_comb begin
    link.v_phase = ccd_seq_pkg::VPHASE_IDLE;
    if (state_q == ST_VSHIFT) begin
      link.v_phase = vseq_phase; // [R2]
    end else if (state_q == ST_INTEG && !pinned_q) begin
      link.v_phase = ccd_seq_pkg::VPHASE_BURIED_HOLD; // [R11]
    end else if (state_q == ST_INTEG) begin
      link.v_phase = ccd_seq_pkg::VPHASE_IDLE; // [R10]
    end
  end

  assign link.row_to_serial_gate = vseq_phase[1]; // [R4] [R3]
  assign link.h_phase = hseq_phase; // [R5]
  // Precharge in the first third of every cell, except ahead of the second cell of a binned pair
  assign link.reset_clk = hseq_phase[0] && (!hbin_q || !pix_q[0]); // [R8]

  ////////////////////////////////////////////////////////////////////////////
  // Video capture
  logic h3_prev_q;
  logic fall_q;
  logic [IW-1:0] end_pix_q;
  logic [RW-1:0] end_line_q;
  logic [ccd_seq_pkg::NODE_W-1:0] sample_q, sample_d;
  logic valid_q, valid_d;
  logic dark_q, dark_d;
  logic [RW-1:0] sline_q, sline_d;

  always_comb begin
    sample_d = sample_q;
    dark_d = dark_q;
    sline_d = sline_q;
    valid_d = 1'b0;
    if (fall_q && (!hbin_q || end_pix_q[0])) begin // [R7] [R8]
      sample_d = link.video;
      dark_d = end_pix_q < DARK_END; // [R6]
      sline_d = end_line_q;
      valid_d = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      h3_prev_q <= 1'b0;
      fall_q <= 1'b0;
      end_pix_q <= '0;
      end_line_q <= '0;
      sample_q <= '0;
      valid_q <= 1'b0;
      dark_q <= 1'b0;
      sline_q <= '0;
    end else begin
      h3_prev_q <= hseq_phase[2];
      fall_q <= h3_prev_q && !hseq_phase[2]; // [R7]
      if (h_end) begin
        end_pix_q <= pix_q;
        end_line_q <= line_q;
      end
      sample_q <= sample_d;
      valid_q <= valid_d;
      dark_q <= dark_d;
      sline_q <= sline_d;
    end
  end

  assign o_busy = state_q != ST_IDLE;
  assign o_frame_done = done_q;
  assign o_sample = sample_q;
  assign o_sample_valid = valid_q;
  assign o_sample_dark = dark_q;
  assign o_sample_line = sline_q;
endmodule : ccd_timing_gen

/* ccd_seq_pkg.sv */
// Shared constants for the full frame sensor clock sequencer and the sensor end.
// Assumes one 10 MHz reference clock shared by both ends.
package ccd_seq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Array geometry
  localparam int ROWS = 512;
  localparam int COLS = 512;
  localparam int DARK_CELLS = 16;
  localparam int HREG_CELLS = DARK_CELLS + COLS;
  localparam int ROW_W = 9;
  localparam int CELL_IDX_W = 10;

  ////////////////////////////////////////////////////////////////////////////
  // Timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int H_RATE_KHZ = 1000;
  localparam int H_CYCLE_CLKS = 1000000 / (H_RATE_KHZ * CLK_PERIOD_NS);
  localparam int V_SHIFT_NS = 6000;
  localparam int V_SHIFT_CLKS = V_SHIFT_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  // Charge widths and levels
  localparam int SAMPLE_W = 12;
  localparam int CELL_W = 13;
  localparam int NODE_W = 14;
  localparam logic [NODE_W-1:0] CELL_MAX = 14'h1fff;
  localparam logic [NODE_W-1:0] NODE_MAX = 14'h3fff;
  localparam logic [2:0] VPHASE_IDLE = 3'h0;
  localparam logic [2:0] VPHASE_BURIED_HOLD = 3'h1;

  // Saturating sum of two charge amounts
  function automatic logic [NODE_W-1:0] sat_add(input logic [NODE_W-1:0] a, input logic [NODE_W-1:0] b,
                                               input logic [NODE_W-1:0] max);
    logic [NODE_W:0] sum;
    sum = {1'b0, a} + {1'b0, b};
    if (sum > {1'b0, max}) begin
      sat_add = max;
    end else begin
      sat_add = sum[NODE_W-1:0];
    end
  endfunction : sat_add

endpackage : ccd_seq_pkg

/* ccd_link_if.sv */
// Phase clock and video link between the timing generator and the sensor.
// Assumes both ends run on the same reference clock.
`timescale 1ns/1ps
interface ccd_link_if;
  logic [2:0] v_phase;
  logic row_to_serial_gate;
  logic [2:0] h_phase;
  logic reset_clk;
  logic [ccd_seq_pkg::NODE_W-1:0] video;

  modport sensor (
    input v_phase,
    input row_to_serial_gate,
    input h_phase,
    input reset_clk,
    output video
  );

  modport timing_gen (
    output v_phase,
    output row_to_serial_gate,
    output h_phase,
    output reset_clk,
    input video
  );
endinterface : ccd_link_if

/* phase_sequencer.sv */
// Three phase clock generator: one phase per third of a cycle while running.
// Assumes i_run comes from a register of the instantiating module.
`timescale 1ns/1ps
module phase_sequencer #(
  parameter int CYCLE_CLKS = 10
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_run,
  output logic [2:0] o_phase,
  output logic o_cycle_end
);
  localparam int CNT_W = $clog2(CYCLE_CLKS);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLE_CLKS - 1);
  localparam logic [CNT_W-1:0] T1 = CNT_W'(CYCLE_CLKS / 3);
  localparam logic [CNT_W-1:0] T2 = CNT_W'((2 * CYCLE_CLKS) / 3);

  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_d;

  always_comb begin
    cnt_d = '0;
    if (i_run && cnt_q != LAST) begin
      cnt_d = cnt_q + 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  always_comb begin
    o_phase = 3'h0;
    if (i_run) begin
      if (cnt_q < T1) begin
        o_phase = 3'h1;
      end else if (cnt_q < T2) begin
        o_phase = 3'h2;
      end else begin
        o_phase = 3'h4;
      end
    end
  end

  assign o_cycle_end = i_run && (cnt_q == LAST);
endmodule : phase_sequencer

/* ccd_sensor_array.sv */
// Sensor end: vertical transfer into the serial register, serial shift and output node.
// Assumes the timing generator keeps to its own sequencing duties on the link.
`timescale 1ns/1ps
module ccd_sensor_array #(
  parameter int ROWS = ccd_seq_pkg::ROWS,
  parameter int COLS = ccd_seq_pkg::COLS,
  parameter int DARK_CELLS = ccd_seq_pkg::DARK_CELLS
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  ccd_link_if.sensor link,
  input wire logic [ccd_seq_pkg::SAMPLE_W-1:0] i_scene_level,
  output logic [ccd_seq_pkg::ROW_W-1:0] o_row_ptr,
  output logic o_vclocks_low
);
  localparam int CELLS = DARK_CELLS + COLS;
  localparam int NW = ccd_seq_pkg::NODE_W;

  logic [ccd_seq_pkg::CELL_W-1:0] hreg_q [CELLS];
  logic [ccd_seq_pkg::CELL_W-1:0] hreg_d [CELLS];
  logic [NW-1:0] node_q, node_d;
  logic [NW-1:0] video_q, video_d;
  logic [ccd_seq_pkg::ROW_W-1:0] row_q, row_d;
  logic gate_prev_q;
  logic h3_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // Charge movement
  always_comb begin
    logic [NW-1:0] sum;
    logic [NW-1:0] site;
    sum = '0;
    site = '0;
    hreg_d = hreg_q;
    node_d = node_q;
    video_d = video_q;
    row_d = row_q;
    // Packet reaches the node on the H3 falling edge and drives the output
    if (h3_prev_q && !link.h_phase[2]) begin // [R7]
      sum = ccd_seq_pkg::sat_add(node_q, NW'(hreg_q[0]), ccd_seq_pkg::NODE_MAX);
      node_d = sum;
      video_d = sum;
      for (int i = 0; i < CELLS - 1; i++) begin
        hreg_d[i] = hreg_q[i + 1];
      end
      hreg_d[CELLS-1] = '0; // [R6]
    end
    // Precharge; skipped pulses leave charge summing in the node
    if (link.reset_clk) begin
      node_d = '0;
    end
    // Bottom row enters the cells behind the empty leading ones, adding to what is there
    if (link.row_to_serial_gate && !gate_prev_q) begin // [R3]
      for (int c = 0; c < COLS; c++) begin
        site = NW'(i_scene_level) + NW'(c[3:0]) + NW'(row_q[3:0]);
        hreg_d[DARK_CELLS + c] = ccd_seq_pkg::CELL_W'(ccd_seq_pkg::sat_add(NW'(hreg_d[DARK_CELLS + c]), site,
                                                                          ccd_seq_pkg::CELL_MAX)); // [R9]
      end
      if (row_q == ccd_seq_pkg::ROW_W'(ROWS - 1)) begin // [R1]
        row_d = '0;
      end else begin
        row_d = row_q + 1'b1;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < CELLS; i++) begin
        hreg_q[i] <= '0;
      end
      node_q <= '0;
      video_q <= '0;
      row_q <= '0;
      gate_prev_q <= 1'b0;
      h3_prev_q <= 1'b0;
    end else begin
      hreg_q <= hreg_d;
      node_q <= node_d;
      video_q <= video_d;
      row_q <= row_d;
      gate_prev_q <= link.row_to_serial_gate;
      h3_prev_q <= link.h_phase[2];
    end
  end

  assign link.video = video_q;
  assign o_row_ptr = row_q;
  assign o_vclocks_low = (link.v_phase == ccd_seq_pkg::VPHASE_IDLE) && !link.row_to_serial_gate;
endmodule : ccd_sensor_array

/* ccd_link_monitor.sv */
// Checker for the phase clock and video link between the two ends.
// Assumes one reference clock and an active low asynchronous reset.
`timescale 1ns/1ps
module ccd_link_monitor (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic [2:0] v_phase,
  input wire logic row_to_serial_gate,
  input wire logic [2:0] h_phase,
  input wire logic reset_clk,
  input wire logic [ccd_seq_pkg::NODE_W-1:0] video
);
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  ////////////////////////////////////////////////////////////////////////////
  // Vertical side
  gate_follows_v2_a: assert property (row_to_serial_gate == v_phase[1])
    else $error("transfer gate differs from second vertical phase");
  v_one_hot_a: assert property ($onehot0(v_phase))
    else $error("vertical phases overlap");
  v3_after_v2_a: assert property ($rose(v_phase[2]) |-> $past(v_phase) == 3'h2)
    else $error("third vertical phase out of order");

  ////////////////////////////////////////////////////////////////////////////
  // Horizontal side
  h_one_hot_a: assert property ($onehot0(h_phase))
    else $error("horizontal phases overlap");
  h2_after_h1_a: assert property ($rose(h_phase[1]) |-> $past(h_phase) == 3'h1)
    else $error("second horizontal phase out of order");
  h3_after_h2_a: assert property ($rose(h_phase[2]) |-> $past(h_phase) == 3'h2)
    else $error("third horizontal phase out of order");
  h_not_in_shift_a: assert property (h_phase != 3'h0 |-> v_phase == 3'h0)
    else $error("horizontal phase during line shift");
  precharge_first_a: assert property (reset_clk |-> h_phase == 3'h1)
    else $error("precharge outside first pixel third");
  video_after_h3_a: assert property (!$stable(video) |-> $past(h_phase[2], 2) && !$past(h_phase[2]))
    else $error("video changed away from third phase fall");

  cover property ($fell(h_phase[2]));
  cover property ($rose(row_to_serial_gate));
  cover property (v_phase == 3'h1 && h_phase == 3'h0);
endmodule : ccd_link_monitor

/* ccd_full_frame_clock_sequencer_tb_top.sv */
// Self-checking bench: timing generator and sensor end joined by the link.
// Assumes shortened geometry and timing set by the parameters below.
`timescale 1ns/1ps
module ccd_full_frame_clock_sequencer_tb_top;
  localparam int NR = 4;
  localparam int NC = 4;
  localparam int HC = 3;
  logic i_ref_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic i_start = 1'b0;
  logic i_pinned_mode = 1'b0;
  logic [31:0] i_integ_clks = 32'h0;
  logic i_vbin_two = 1'b0;
  logic i_hbin_two = 1'b0;
  logic [11:0] i_scene_level = 12'h0;
  logic o_busy, o_frame_done, o_sample_valid, o_sample_dark, o_vclocks_low;
  logic [13:0] o_sample;
  logic [8:0] o_sample_line, o_row_ptr;
  logic [11:0] lv;
  int errors = 0, tests_run = 0, sl = 0, sk = 0, ns = 0, cyc = 0, lastv = 0, vb = 0, hb = 0;

  ccd_link_if link ();
  ccd_timing_gen #(.ROWS(NR), .COLS(NC), .H_CLKS(HC), .V_CLKS(6)) u_ccd_timing_gen (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link), .i_start(i_start),
    .i_pinned_mode(i_pinned_mode), .i_integ_clks(i_integ_clks), .i_vbin_two(i_vbin_two),
    .i_hbin_two(i_hbin_two), .o_busy(o_busy), .o_frame_done(o_frame_done), .o_sample(o_sample),
    .o_sample_valid(o_sample_valid), .o_sample_dark(o_sample_dark), .o_sample_line(o_sample_line));
  ccd_sensor_array #(.ROWS(NR), .COLS(NC)) u_ccd_sensor_array (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .link(link), .i_scene_level(i_scene_level),
    .o_row_ptr(o_row_ptr), .o_vclocks_low(o_vclocks_low));
  ccd_link_monitor u_ccd_link_monitor (
    .i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .v_phase(link.v_phase),
    .row_to_serial_gate(link.row_to_serial_gate), .h_phase(link.h_phase),
    .reset_clk(link.reset_clk), .video(link.video));

  initial begin
    forever #50 i_ref_clk = ~i_ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checking helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] t=%0t got %0h exp %0h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : stop_test

  // Node charge of sample k of line l: rows summed per cell, cell pairs per node
  function automatic logic [13:0] exp_px(input int l, input int k);
    int n, c, s;
    n = 0;
    for (int i = 0; i <= hb; i++) begin
      c = hb ? 2 * k + i : k;
      s = 0;
      for (int r = 0; r <= vb && c >= ccd_seq_pkg::DARK_CELLS; r++) begin
        s += lv + (c - ccd_seq_pkg::DARK_CELLS) % 16 + (vb ? 2 * l + r : l) % 16;
      end
      n += (s > ccd_seq_pkg::CELL_MAX) ? ccd_seq_pkg::CELL_MAX : s;
    end
    return (n > ccd_seq_pkg::NODE_MAX) ? ccd_seq_pkg::NODE_MAX : 14'(n);
  endfunction : exp_px

  // Outputs are looked at mid-cycle, where they have settled
  always @(negedge i_ref_clk) begin
    cyc++;
    if (o_sample_valid === 1'b1) begin
      chk(o_sample, exp_px(sl, sk));
      chk(o_sample_dark, (hb ? 2 * sk : sk) < ccd_seq_pkg::DARK_CELLS);
      chk(o_sample_line, sl);
      chk(o_row_ptr, ((sl + 1) * (vb + 1)) % NR);
      if (sk > 0) begin
        chk(cyc - lastv, HC * (hb + 1));
      end
      lastv = cyc;
      sk++;
      ns++;
      if (sk == (16 + NC) / (hb + 1)) begin
        sk = 0;
        sl++;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame runner
  task automatic run_frame(input int pm, input int v, input int h, input logic [11:0] lvl);
    int n;
    n = 0;
    vb = v;
    hb = h;
    lv = lvl;
    sl = 0;
    sk = 0;
    ns = 0;
    @(posedge i_ref_clk);
    i_pinned_mode <= pm[0];
    i_vbin_two <= v[0];
    i_hbin_two <= h[0];
    i_scene_level <= lvl;
    i_integ_clks <= 32'($urandom_range(8, 4));
    i_start <= 1'b1;
    @(posedge i_ref_clk);
    i_start <= 1'b0;
    repeat (2) @(posedge i_ref_clk);
    #1;
    chk(o_busy, 1);
    chk(link.v_phase, pm ? 3'h0 : 3'h1);
    chk(o_vclocks_low, pm);
    while (o_frame_done !== 1'b1 && n < 20000) begin
      @(posedge i_ref_clk);
      n++;
    end
    if (n >= 20000) begin
      errors++;
      stop_test();
    end
    // Frame done is a single cycle pulse
    @(negedge i_ref_clk);
    chk(o_frame_done, 0);
    repeat (3) @(posedge i_ref_clk);
    chk(ns, (NR / (v + 1)) * ((16 + NC) / (h + 1)));
    chk(o_busy, 0);
    $display("Frame done: pinned %0d vbin %0d hbin %0d level %0h", pm, v, h, lvl);
  endtask : run_frame

  initial begin
    void'($urandom(32'h40fd));
    repeat (20) @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      run_frame(i[0] ^ i[1], i / 2, i % 2, 12'($urandom));
    end
    // Reset during a line shift drops every link clock
    @(posedge i_ref_clk);
    i_start <= 1'b1;
    repeat (12) @(posedge i_ref_clk);
    i_rst_n <= 1'b0;
    i_start <= 1'b0;
    @(posedge i_ref_clk);
    #1;
    chk({o_busy, link.h_phase, link.v_phase, link.reset_clk}, 0);
    @(posedge i_ref_clk);
    i_rst_n <= 1'b1;
    $display("Mid-frame reset done");
    run_frame(1, 1, 1, 12'hfff);
    run_frame(0, 0, 0, 12'h000);
    stop_test();
  end
endmodule : ccd_full_frame_clock_sequencer_tb_top
